//--- hw/tsr_pkg.sv
// Constants and types shared by the touch sensor host register bank
package tsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TSR_LOCK_OFS    = 8'h79;
  localparam logic [7:0] TSR_STATUS_OFS  = 8'h7b;
  localparam logic [7:0] TSR_ADDR_DM_OFS = 8'h7c;
  localparam logic [7:0] TSR_SEL_OFS     = 8'h81;
  localparam logic [7:0] TSR_BL_MSB_OFS  = 8'h82;
  localparam logic [7:0] TSR_BL_LSB_OFS  = 8'h83;
  localparam logic [7:0] TSR_DIF_MSB_OFS = 8'h84;
  localparam logic [7:0] TSR_DIF_LSB_OFS = 8'h85;
  localparam logic [7:0] TSR_RAW_MSB_OFS = 8'h86;
  localparam logic [7:0] TSR_RAW_LSB_OFS = 8'h87;
  localparam logic [7:0] TSR_BTN_ST_OFS  = 8'h88;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TSR_ST_SUPPLY_LSB = 6;
  localparam int TSR_ST_INTERNAL_RESET_FLAG_BIT   = 5;
  localparam int TSR_ST_FD_BIT     = 4;
  localparam int TSR_ST_BLK_BIT    = 3;
  localparam int TSR_ST_CSE_BIT    = 1;
  localparam int TSR_ST_OUTPUT_BLOCK_ENABLED_FLAG_BIT   = 0;
  localparam int TSR_PULLUP_BIT    = 7;
  localparam int TSR_RD_EN_BIT     = 7;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] TSR_ADDR_DM_RST = 8'h00;
  localparam logic [7:0] TSR_SEL_RST     = 8'h00;
  localparam logic       TSR_LOCK_RST    = 1'b0;
  localparam logic [1:0] TSR_BTN_RST     = 2'h0;
  localparam int         TSR_BTN_NUM     = 2;
  localparam int         TSR_WIN_BYTES   = 6;

  // ----------------------------------------------------------------
  // Lock register key sequences, first byte first
  // ----------------------------------------------------------------
  localparam logic [23:0] TSR_UNLOCK_KEY = 24'h3ca569;
  localparam logic [23:0] TSR_LOCK_KEY   = 24'h965ac3;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TSR_IDLE      = 3'b000,
    TSR_ADDR      = 3'b001,
    TSR_ADDR_ACK  = 3'b010,
    TSR_WRITE     = 3'b011,
    TSR_WRITE_ACK = 3'b100,
    TSR_READ      = 3'b101,
    TSR_READ_ACK  = 3'b110
  } tsr_i2c_st_t;

endpackage

//--- hw/tsr_addr_lock.sv
// Key sequence tracker for the address lock register
module tsr_addr_lock
  import tsr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Register write strobe
  input  wire logic       i_wr_stb,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  // Lock state
  output logic            o_locked,
  output logic            o_relock
);
  typedef struct packed {
    logic [1:0] unl_idx;
    logic [1:0] lck_idx;
    logic       locked;
    logic       relock;
  } tsr_lock_t;

  tsr_lock_t s_r, s_nxt;

  // ----------------------------------------------------------------
  // Three-byte key match, a wrong byte restarts the key
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] unl_exp;
    logic [7:0] lck_exp;
    unl_exp = TSR_UNLOCK_KEY[8'(23 - 8 * s_r.unl_idx) -: 8];
    lck_exp = TSR_LOCK_KEY[8'(23 - 8 * s_r.lck_idx) -: 8];
    s_nxt = s_r;
    s_nxt.relock = 1'b0;
    if (i_wr_stb && i_wr_addr == TSR_LOCK_OFS) begin
      if (i_wr_data == unl_exp) begin
        s_nxt.unl_idx = (s_r.unl_idx == 2'h2) ? 2'h0 : s_r.unl_idx + 2'h1;
        if (s_r.unl_idx == 2'h2) begin
          s_nxt.locked = 1'b0;
        end
      end else begin
        s_nxt.unl_idx = (i_wr_data == TSR_UNLOCK_KEY[23:16]) ? 2'h1 : 2'h0;
      end
      if (i_wr_data == lck_exp) begin
        s_nxt.lck_idx = (s_r.lck_idx == 2'h2) ? 2'h0 : s_r.lck_idx + 2'h1;
        if (s_r.lck_idx == 2'h2) begin
          s_nxt.locked = 1'b1;
          s_nxt.relock = 1'b1;
        end
      end else begin
        s_nxt.lck_idx = (i_wr_data == TSR_LOCK_KEY[23:16]) ? 2'h1 : 2'h0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_r <= '{unl_idx: 2'h0, lck_idx: 2'h0, locked: TSR_LOCK_RST, relock: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_locked = s_r.locked;
  assign o_relock = s_r.relock;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_relock_edge: assert property ($rose(o_locked) |-> o_relock)
    else $error("lock taken without relock pulse");
  a_relock_once: assert property (o_relock |=> !o_relock)
    else $error("relock pulse longer than one cycle");
endmodule

//--- hw/tsr_readout_sel.sv
// Readout selector register and selected-button result window
module tsr_readout_sel
  import tsr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // Register write strobe
  input  wire logic        i_wr_stb,
  input  wire logic [7:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  // Sensing pins and results, button n in slice n
  input  wire logic [1:0]  i_sense_pin_mask,
  input  wire logic [31:0] i_baseline,
  input  wire logic [31:0] i_difference,
  input  wire logic [31:0] i_raw_count,
  // Register view
  output logic [7:0]       o_sel,
  output logic [47:0]      o_window
);
  typedef struct packed {
    logic [7:0]  sel;
    logic [47:0] win;
  } tsr_sel_t;

  tsr_sel_t s_r, s_nxt;
  logic [47:0] win_nxt;
  logic        onehot;
  logic [15:0] bl_pick, dif_pick, raw_pick;

  assign onehot   = ^i_wr_data[1:0];
  assign bl_pick  = s_r.sel[1] ? i_baseline[31:16]   : i_baseline[15:0];
  assign dif_pick = s_r.sel[1] ? i_difference[31:16] : i_difference[15:0];
  assign raw_pick = s_r.sel[1] ? i_raw_count[31:16]  : i_raw_count[15:0];

  // ----------------------------------------------------------------
  // Window bytes, MSB at the lower offset, zero while reading is off
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < TSR_WIN_BYTES; k++) begin : g_win
      logic [15:0] src;
      assign src = (k < 2) ? bl_pick : (k < 4) ? dif_pick : raw_pick;
      assign win_nxt[8*k +: 8] = !s_r.sel[TSR_RD_EN_BIT] ? 8'h00 :
                                 (k % 2 == 0) ? src[15:8] : src[7:0];
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    s_nxt.win = win_nxt;
    if (i_wr_stb && i_wr_addr == TSR_SEL_OFS && onehot &&
        (i_wr_data[1:0] & i_sense_pin_mask) != 2'h0) begin
      s_nxt.sel = {i_wr_data[TSR_RD_EN_BIT], 5'h00, i_wr_data[1:0]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_r <= '{sel: TSR_SEL_RST, win: 48'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sel    = s_r.sel;
  assign o_window = s_r.win;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  a_sel_discard: assert property (i_wr_stb && i_wr_addr == TSR_SEL_OFS &&
      !(^i_wr_data[1:0]) |=> $stable(o_sel))
    else $error("non one-hot select was accepted");
  a_sel_nonsense: assert property (i_wr_stb && i_wr_addr == TSR_SEL_OFS &&
      (i_wr_data[1:0] & i_sense_pin_mask) == 2'h0 |=> $stable(o_sel))
    else $error("select of a non-sensing pin was accepted");
  a_win_off: assert property (!o_sel[TSR_RD_EN_BIT] |=> o_window == 48'h0)
    else $error("window not zero while reading disabled");
  a_win_msb: assert property (o_sel == 8'h81 && $stable(i_baseline)
      |=> o_window[7:0] == $past(i_baseline[15:8]) && o_window[15:8] == $past(i_baseline[7:0]))
    else $error("baseline byte order wrong");
endmodule

//--- hw/tsr_host_regs.sv
// Serial slave port and host register bank of the touch sensor controller
// Functional notes
// - Status register packs supply, reset, flags
// - Default-source flag: 1 when factory defaults loaded
// - Low supply sets blocked flag, stops writes
// - Sensing-enable flag mirrors sensing block state
// - Output-enable flag mirrors output block state
// - Address bit 7 disables pin pull-up
// - Address bits 6:0 are the slave address
// - Address register writable only while unlocked
// - New address applies only after relocking
// - Window shows one selected input only
// - Only sensing pins may be selected
// - Selector bit 7 enables result reading
// - Button select must be one-hot
// - Baseline bytes give selected baseline
// - Difference bytes give selected difference count
// - Raw bytes give selected raw count
// - Button status bit per button, 1 touched
module tsr_host_regs
  import tsr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // Serial bus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  output logic             o_pullup_disable,
  output logic [6:0]       o_slave_address,
  // Device status sources
  input  wire logic [1:0]  i_supply_level,
  input  wire logic        i_internal_reset,
  input  wire logic        i_factory_default_loaded,
  input  wire logic        i_supply_too_low,
  input  wire logic        i_sensing_enabled,
  input  wire logic        i_output_enabled,
  // Nonvolatile write gate
  input  wire logic        i_nvm_write_req,
  output logic             o_nvm_write_go,
  output logic             o_nvm_write_blocked,
  // Sensing results, button n in slice n
  input  wire logic [1:0]  i_sense_pin_mask,
  input  wire logic [1:0]  i_button_on,
  input  wire logic [31:0] i_baseline,
  input  wire logic [31:0] i_difference,
  input  wire logic [31:0] i_raw_count
);
  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    tsr_i2c_st_t state;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        got_ptr;
    logic        rw;
    logic        sda_oe_n;
    logic        sda_o;
    logic        wr_stb;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [6:0]  addr_act;
    logic        pull_dis;
    logic [7:0]  addr_pend;
    logic        blocked;
    logic        nvm_go;
    logic [7:0]  status;
    logic [1:0]  btn;
  } tsr_regs_t;

  tsr_regs_t   s_r, s_nxt;
  logic        locked, relock;
  logic [7:0]  sel;
  logic [47:0] window;
  logic [7:0]  rd_val;
  logic        scl_rise, scl_fall, bus_start, bus_stop;

  // ----------------------------------------------------------------
  // Address lock and readout selector
  // ----------------------------------------------------------------
  tsr_addr_lock u_lock (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_wr_stb  (s_r.wr_stb),
    .i_wr_addr (s_r.wr_addr),
    .i_wr_data (s_r.wr_data),
    .o_locked  (locked),
    .o_relock  (relock)
  );

  tsr_readout_sel u_sel (
    .i_clk_sys        (i_clk_sys),
    .i_sys_rst        (i_sys_rst),
    .i_wr_stb         (s_r.wr_stb),
    .i_wr_addr        (s_r.wr_addr),
    .i_wr_data        (s_r.wr_data),
    .i_sense_pin_mask (i_sense_pin_mask),
    .i_baseline       (i_baseline),
    .i_difference     (i_difference),
    .i_raw_count      (i_raw_count),
    .o_sel            (sel),
    .o_window         (window)
  );

  // ----------------------------------------------------------------
  // Read data multiplexer, unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    unique case (s_r.ptr)
      TSR_LOCK_OFS:    rd_val = {7'h00, locked};
      TSR_STATUS_OFS:  rd_val = s_r.status;
      TSR_ADDR_DM_OFS: rd_val = {s_r.pull_dis, s_r.addr_act};
      TSR_SEL_OFS:     rd_val = sel;
      TSR_BL_MSB_OFS:  rd_val = window[7:0];
      TSR_BL_LSB_OFS:  rd_val = window[15:8];
      TSR_DIF_MSB_OFS: rd_val = window[23:16];
      TSR_DIF_LSB_OFS: rd_val = window[31:24];
      TSR_RAW_MSB_OFS: rd_val = window[39:32];
      TSR_RAW_LSB_OFS: rd_val = window[47:40];
      TSR_BTN_ST_OFS:  rd_val = {6'h00, s_r.btn};
      default:         rd_val = 8'h00;
    endcase
  end

  assign scl_rise  = i_scl & ~s_r.scl_q;
  assign scl_fall  = ~i_scl & s_r.scl_q;
  assign bus_start = s_r.scl_q & i_scl & s_r.sda_q & ~i_sda;
  assign bus_stop  = s_r.scl_q & i_scl & ~s_r.sda_q & i_sda;

  // ----------------------------------------------------------------
  // Next state: serial slave, register writes, status capture
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_q  = i_scl;
    s_nxt.sda_q  = i_sda;
    s_nxt.sda_o  = 1'b0;
    s_nxt.wr_stb = 1'b0;

    // Status flags
    s_nxt.status = 8'h00;
    s_nxt.status[TSR_ST_SUPPLY_LSB +: 2] = i_supply_level;
    s_nxt.status[TSR_ST_INTERNAL_RESET_FLAG_BIT] = i_internal_reset;
    s_nxt.status[TSR_ST_FD_BIT]   = i_factory_default_loaded;
    s_nxt.status[TSR_ST_BLK_BIT]  = i_supply_too_low;
    s_nxt.status[TSR_ST_CSE_BIT]  = i_sensing_enabled;
    s_nxt.status[TSR_ST_OUTPUT_BLOCK_ENABLED_FLAG_BIT] = i_output_enabled;
    s_nxt.btn     = i_button_on;
    s_nxt.blocked = i_supply_too_low;
    s_nxt.nvm_go  = i_nvm_write_req & ~i_supply_too_low;

    // Address register: staged while unlocked, applied on relock
    if (s_r.wr_stb && s_r.wr_addr == TSR_ADDR_DM_OFS && !locked) begin
      s_nxt.addr_pend = s_r.wr_data;
    end
    if (relock) begin
      s_nxt.addr_act = s_r.addr_pend[6:0];
      s_nxt.pull_dis = s_r.addr_pend[TSR_PULLUP_BIT];
    end

    // Serial slave
    if (bus_start) begin
      s_nxt.state    = TSR_ADDR;
      s_nxt.cnt      = 4'h0;
      s_nxt.got_ptr  = 1'b0;
      s_nxt.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      s_nxt.state    = TSR_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else begin
      unique case (s_r.state)
        TSR_IDLE: begin
          s_nxt.sda_oe_n = 1'b1;
        end
        TSR_ADDR, TSR_WRITE: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], i_sda};
            s_nxt.cnt   = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == 4'h8) begin
            s_nxt.cnt = 4'h0;
            if (s_r.state == TSR_ADDR) begin
              if (s_r.shreg[7:1] == s_r.addr_act) begin
                s_nxt.state    = TSR_ADDR_ACK;
                s_nxt.rw       = s_r.shreg[0];
                s_nxt.sda_oe_n = 1'b0;
              end else begin
                s_nxt.state = TSR_IDLE;
              end
            end else begin
              s_nxt.state    = TSR_WRITE_ACK;
              s_nxt.sda_oe_n = 1'b0;
              if (!s_r.got_ptr) begin
                s_nxt.ptr     = s_r.shreg;
                s_nxt.got_ptr = 1'b1;
              end else begin
                s_nxt.wr_stb  = 1'b1;
                s_nxt.wr_addr = s_r.ptr;
                s_nxt.wr_data = s_r.shreg;
                s_nxt.ptr     = s_r.ptr + 8'h01;
              end
            end
          end
        end
        TSR_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_r.rw) begin
              s_nxt.state    = TSR_READ;
              s_nxt.shreg    = rd_val;
              s_nxt.sda_oe_n = rd_val[7];
              s_nxt.cnt      = 4'h1;
            end else begin
              s_nxt.state    = TSR_WRITE;
              s_nxt.sda_oe_n = 1'b1;
            end
          end
        end
        TSR_WRITE_ACK: begin
          if (scl_fall) begin
            s_nxt.state    = TSR_WRITE;
            s_nxt.sda_oe_n = 1'b1;
          end
        end
        TSR_READ: begin
          if (scl_fall) begin
            if (s_r.cnt == 4'h8) begin
              s_nxt.state    = TSR_READ_ACK;
              s_nxt.sda_oe_n = 1'b1;
              s_nxt.ptr      = s_r.ptr + 8'h01;
            end else begin
              s_nxt.shreg    = {s_r.shreg[6:0], 1'b0};
              s_nxt.sda_oe_n = s_r.shreg[6];
              s_nxt.cnt      = s_r.cnt + 4'h1;
            end
          end
        end
        TSR_READ_ACK: begin
          if (scl_rise && i_sda) begin
            s_nxt.state = TSR_IDLE;
          end else if (scl_fall) begin
            s_nxt.state    = TSR_READ;
            s_nxt.shreg    = rd_val;
            s_nxt.sda_oe_n = rd_val[7];
            s_nxt.cnt      = 4'h1;
          end
        end
        default: begin
          s_nxt.state    = TSR_IDLE;
          s_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s_r <= '{scl_q: 1'b1, sda_q: 1'b1, state: TSR_IDLE, cnt: 4'h0,
               shreg: 8'h00, ptr: 8'h00, got_ptr: 1'b0, rw: 1'b0,
               sda_oe_n: 1'b1, sda_o: 1'b0, wr_stb: 1'b0, wr_addr: 8'h00,
               wr_data: 8'h00, addr_act: TSR_ADDR_DM_RST[6:0],
               pull_dis: TSR_ADDR_DM_RST[TSR_PULLUP_BIT],
               addr_pend: TSR_ADDR_DM_RST, blocked: 1'b0, nvm_go: 1'b0,
               status: 8'h00, btn: TSR_BTN_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_sda               = s_r.sda_o;
  assign o_sda_oe_n          = s_r.sda_oe_n;
  assign o_pullup_disable    = s_r.pull_dis;
  assign o_slave_address     = s_r.addr_act;
  assign o_nvm_write_go      = s_r.nvm_go;
  assign o_nvm_write_blocked = s_r.blocked;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_own_addr_done;
    s_r.state == TSR_ADDR && scl_fall && !bus_start && !bus_stop &&
    s_r.cnt == 4'h8 && s_r.shreg[7:1] == s_r.addr_act;
  endsequence
  sequence s_ack_driven;
    s_r.state == TSR_ADDR_ACK && !o_sda_oe_n;
  endsequence

  a_addr_ack: assert property (s_own_addr_done |=> s_ack_driven)
    else $error("own address not acknowledged");
  a_nvm_gate: assert property (i_supply_too_low |=> !o_nvm_write_go && o_nvm_write_blocked)
    else $error("nvm write passed at low supply");
  a_status_map: assert property (##1 s_r.status == {$past(i_supply_level),
      $past(i_internal_reset), $past(i_factory_default_loaded),
      $past(i_supply_too_low), 1'b0, $past(i_sensing_enabled), $past(i_output_enabled)})
    else $error("status register layout wrong");
  a_addr_hold: assert property (!relock |=> $stable(o_slave_address) &&
      $stable(o_pullup_disable))
    else $error("address changed without relock");
  a_addr_apply: assert property (relock |=> o_slave_address == $past(s_r.addr_pend[6:0]) &&
      o_pullup_disable == $past(s_r.addr_pend[7]))
    else $error("staged address not applied on relock");
  a_addr_locked: assert property (s_r.wr_stb && s_r.wr_addr == TSR_ADDR_DM_OFS && locked
      |=> $stable(s_r.addr_pend))
    else $error("address write accepted while locked");
  a_btn_status: assert property (##1 s_r.btn == $past(i_button_on))
    else $error("button status not tracking sensors");

  // Framing: foreign frames, stop, write hand-off, read start
  sequence s_other_addr_done;
    s_r.state == TSR_ADDR && scl_fall && !bus_start && !bus_stop &&
    s_r.cnt == 4'h8 && s_r.shreg[7:1] != s_r.addr_act;
  endsequence
  sequence s_data_byte_done;
    s_r.state == TSR_WRITE && scl_fall && !bus_start && !bus_stop &&
    s_r.cnt == 4'h8 && s_r.got_ptr;
  endsequence
  sequence s_read_begin;
    s_r.state == TSR_ADDR_ACK && s_r.rw && scl_fall && !bus_start && !bus_stop;
  endsequence

  a_addr_ignore: assert property (s_other_addr_done |=>
      s_r.state == TSR_IDLE && o_sda_oe_n)
    else $error("foreign address acknowledged");
  a_stop_release: assert property (bus_stop |=>
      s_r.state == TSR_IDLE && o_sda_oe_n)
    else $error("data line not released after stop");
  a_wr_handoff: assert property (s_data_byte_done |=> s_r.wr_stb &&
      s_r.wr_addr == $past(s_r.ptr) && s_r.wr_data == $past(s_r.shreg))
    else $error("data byte not handed to the registers");
  a_read_msb: assert property (s_read_begin |=>
      s_r.state == TSR_READ && o_sda_oe_n == $past(rd_val[7]))
    else $error("read byte not started with its top bit");
  a_read_release: assert property (s_r.state == TSR_READ_ACK |-> o_sda_oe_n)
    else $error("data line held during host acknowledge");
  a_nvm_permit: assert property (i_nvm_write_req && !i_supply_too_low |=>
      o_nvm_write_go && !o_nvm_write_blocked)
    else $error("nvm write withheld at good supply");
endmodule

//--- test/tsr_i2c_host_model.sv
// Serial bus host model: drives SCL, pulls SDA low, samples SDA
module tsr_i2c_host_model (
  // Clock
  input  wire logic i_clk_sys,
  // Bus lines
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Each SCL phase lasts 4 clocks
  task automatic hp();
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_low = 1'b0;
    hp();
  endtask
  // Sample SDA mid high phase; a released line reads the pull-up level
  task automatic bit_x(input logic b, output logic r);
    o_sda_low = !b;
    hp();
    o_scl = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    r = i_sda;
    repeat (2) @(negedge i_clk_sys);
    o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack_n);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, r);
  endtask
endmodule

//--- test/tsr_host_regs_tb.sv
// Self-checking bench for the touch sensor host register bank
module tsr_host_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsr_pkg::*;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, nvm_req = 1'b0;
  logic        scl, sda_low, sda_oe_n, sda_q, pud, nvm_go, nvm_blk, ack;
  logic [1:0]  supply = 2'h0, sense_mask = 2'h3, btn_on = 2'h0;
  logic        internal_reset_flag = 1'b0, fdl = 1'b0, too_low = 1'b0, sensing_enabled_flag = 1'b0, output_block_enabled_flag = 1'b0;
  logic [6:0]  slave_addr, dev_addr = 7'h00;
  logic [31:0] bl = 32'hb2b1a2a1, difference_count_field = 32'hc4c3b4b3, raw = 32'hd6d5c6c5;
  logic [47:0] got;
  int          err_count = 0, cmp_count = 0, cycles = 0;
  wire         sda = !sda_low && (sda_oe_n || sda_q);
  always #25 clk_sys = ~clk_sys;
  tsr_host_regs dut_u (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda(sda_q), .o_sda_oe_n(sda_oe_n), .o_pullup_disable(pud),
    .o_slave_address(slave_addr), .i_supply_level(supply), .i_internal_reset(internal_reset_flag),
    .i_factory_default_loaded(fdl), .i_supply_too_low(too_low),
    .i_sensing_enabled(sensing_enabled_flag), .i_output_enabled(output_block_enabled_flag), .i_nvm_write_req(nvm_req),
    .o_nvm_write_go(nvm_go), .o_nvm_write_blocked(nvm_blk),
    .i_sense_pin_mask(sense_mask), .i_button_on(btn_on), .i_baseline(bl),
    .i_difference(difference_count_field), .i_raw_count(raw));
  tsr_i2c_host_model host_u (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [47:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr1(input logic [7:0] p, d);
    host_u.start();
    host_u.wbyte({dev_addr, 1'b0}, ack);
    check("write addr ack", ack, 1'b0);
    host_u.wbyte(p, ack);
    host_u.wbyte(d, ack);
    host_u.stop();
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic rdn(input logic [7:0] p, input int n, output logic [47:0] v);
    logic [7:0] b;
    v = '0;
    host_u.start();
    host_u.wbyte({dev_addr, 1'b0}, ack);
    host_u.wbyte(p, ack);
    host_u.start();
    host_u.wbyte({dev_addr, 1'b1}, ack);
    check("read addr ack", ack, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_u.rbyte(i == n - 1, b);
      v = {v[39:0], b};
    end
    host_u.stop();
  endtask
  // Each key byte goes in its own transfer so the pointer stays on the lock register
  task automatic key(input logic [23:0] k);
    for (int i = 0; i < 3; i++) wr1(TSR_LOCK_OFS, k[23 - 8 * i -: 8]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("slave address", slave_addr, 7'h00);
    check("pullup disable", pud, 1'b0);
    rdn(TSR_SEL_OFS, 1, got);
    check("selector", got, 8'h00);
    rdn(TSR_BTN_ST_OFS, 1, got);
    check("button status", got, 8'h00);
  endtask
  task automatic t_status(input logic [6:0] v, input logic [7:0] e);
    {supply, internal_reset_flag, fdl, too_low, sensing_enabled_flag, output_block_enabled_flag} = v;
    rdn(TSR_STATUS_OFS, 1, got);
    check("status", got, e);
  endtask
  task automatic t_nvm();
    too_low = 1'b1;
    nvm_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("nvm blocked", {nvm_go, nvm_blk}, 2'b01);
    nvm_req = 1'b0;
    too_low = 1'b0;
    rdn(TSR_STATUS_OFS, 1, got);
    nvm_req = !got[TSR_ST_BLK_BIT];
    repeat (3) @(negedge clk_sys);
    check("nvm permitted", {nvm_go, nvm_blk}, 2'b10);
    nvm_req = 1'b0;
  endtask
  task automatic t_lock();
    key(TSR_LOCK_KEY);
    rdn(TSR_LOCK_OFS, 1, got);
    check("lock bit", got[0], 1'b1);
    wr1(TSR_ADDR_DM_OFS, 8'h85);
    key(TSR_UNLOCK_KEY);
    key(TSR_LOCK_KEY);
    check("locked write", {pud, slave_addr}, 8'h00);
    key(TSR_UNLOCK_KEY);
    wr1(TSR_ADDR_DM_OFS, 8'ha5);
    rdn(TSR_ADDR_DM_OFS, 1, got);
    check("staged addr", {got[7:0], pud, slave_addr}, 16'h0000);
    key(TSR_LOCK_KEY);
    check("active addr", {pud, slave_addr}, 8'ha5);
    host_u.start();
    host_u.wbyte(8'h00, ack);
    host_u.stop();
    check("old addr nack", ack, 1'b1);
    dev_addr = 7'h25;
    rdn(TSR_ADDR_DM_OFS, 1, got);
    check("new addr reg", got, 8'ha5);
  endtask
  task automatic t_sel();
    wr1(TSR_SEL_OFS, 8'h81);
    rdn(TSR_BL_MSB_OFS, 6, got);
    check("window b1", got, {bl[15:0], difference_count_field[15:0], raw[15:0]});
    wr1(TSR_SEL_OFS, 8'h82);
    rdn(TSR_BL_MSB_OFS, 6, got);
    check("window b2", got, {bl[31:16], difference_count_field[31:16], raw[31:16]});
    wr1(TSR_SEL_OFS, 8'h83);
    wr1(TSR_SEL_OFS, 8'h80);
    rdn(TSR_SEL_OFS, 1, got);
    check("not one-hot", got, 8'h82);
    sense_mask = 2'b10;
    wr1(TSR_SEL_OFS, 8'h81);
    rdn(TSR_SEL_OFS, 1, got);
    check("non-sensing pin", got, 8'h82);
    wr1(TSR_SEL_OFS, 8'h02);
    rdn(TSR_SEL_OFS, 6, got);
    check("reading off", got, {8'h02, 40'h0});
    btn_on = 2'b10;
    rdn(TSR_BTN_ST_OFS, 1, got);
    check("button on", got, 8'h02);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_status(7'b1011010, 8'hb2);
    t_status(7'b0100101, 8'h49);
    t_nvm();
    t_lock();
    t_sel();
    final_report();
  end
endmodule
